//--- adc_guard_checker.sv
// adc_guard_checker: bus timing assertions
// assumes interface signals as inputs, one clock
`timescale 1ns/1ps
module adc_guard_checker
	import adc_guard_pkg::*;
(
	input wire logic              i_core_clk,
	input wire logic              i_srst,
	input wire logic              req,
	input wire logic              we,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic              wait_n,
	input wire logic              done
);
	// ----
	// checks
	// ----
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_srst);
	sequence slow_s; !wait_n ##1 (wait_n && !done) ##1 done; endsequence
	sequence fast_s; wait_n ##1 done; endsequence
	AST_MODE_WAIT: assert property ($rose(req) && we && addr == ADDR_MODE |-> slow_s)
		else $error("mode write wait");
	AST_CHAN_WAIT: assert property ($rose(req) && we && addr == ADDR_CHAN |-> slow_s)
		else $error("chan write wait");
	AST_READ_WAIT: assert property ($rose(req) && !we && addr == ADDR_RESULT |-> slow_s)
		else $error("result read wait");
	AST_FAST: assert property ($rose(req) && addr == 2'h3 |-> fast_s)
		else $error("fast access");
	AST_CHAN_ZERO: assert property (req && we && addr == ADDR_CHAN |-> !(wdata & CHAN_RSVD_MASK))
		else $error("chan high bits");
	AST_DONE_PULSE: assert property (done |=> !done)
		else $error("done pulse");
	AST_REQ_HOLD: assert property (req && !done |=> done || (req && $stable(addr) && $stable(we)
		&& $stable(wdata)))
		else $error("req hold");
endmodule // adc_guard_checker

//--- adc_guard_cpu.sv
// adc_guard_cpu: bus master end issuing at most one access per command, none for a refused one
// assumes commands arrive only while o_ready is high
`timescale 1ns/1ps
module adc_guard_cpu
	import adc_guard_pkg::*;
(
	input  wire logic                  i_core_clk,
	input  wire logic                  i_srst,
	adc_guard_if.cpu                   bus,
	input  wire logic                  i_cmd_valid,
	input  wire logic                  i_cmd_we,
	input  wire logic [ADDR_W-1:0]     i_cmd_addr,
	input  wire logic [DATA_W-1:0]     i_cmd_wdata,
	input  wire logic                  i_sub_clk_osc_off,
	input  wire logic                  i_conv_done,
	output logic                       o_ready,
	output logic                       o_rsp_valid,
	output logic      [15:0]           o_rsp_data,
	output logic                       o_refused
);
	import adc_guard_pkg::*;
	typedef enum logic [1:0] {IDLE, BUSY} state_e;
	state_e state_q;
	logic req_q;
	logic we_q;
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] wdata_q;
	logic rsp_q;
	logic [15:0] data_q;
	logic ref_q;
	logic conv_ok_q;
	logic bad;
	logic spoil;
	logic spoil_busy;
	// ------------------------------
	// access guard
	// ------------------------------
	assign spoil = i_cmd_we && (i_cmd_addr == ADDR_MODE || i_cmd_addr == ADDR_CHAN);
	// a mode or channel write in flight spoils any result that lands before it commits
	assign spoil_busy = state_q == BUSY && we_q
		&& (addr_q == ADDR_MODE || addr_q == ADDR_CHAN);
	assign bad = i_sub_clk_osc_off && (spoil || (!i_cmd_we && i_cmd_addr == ADDR_RESULT))
		|| (!i_cmd_we && i_cmd_addr == ADDR_RESULT && !conv_ok_q);
	always_ff @(posedge i_core_clk) begin
		if (i_srst) conv_ok_q <= 1'b0;
		else if (i_cmd_valid && o_ready && !bad && spoil) conv_ok_q <= 1'b0;
		else if (spoil_busy && !bus.done) conv_ok_q <= 1'b0;
		else if (i_conv_done) conv_ok_q <= 1'b1;
	end
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			state_q <= IDLE;
			req_q <= 1'b0;
			we_q <= 1'b0;
			addr_q <= '0;
			wdata_q <= '0;
			rsp_q <= 1'b0;
			data_q <= 16'h0000;
			ref_q <= 1'b0;
		end else begin
			rsp_q <= 1'b0;
			ref_q <= 1'b0;
			case (state_q)
				IDLE: if (i_cmd_valid) begin
					if (bad) ref_q <= 1'b1;
					else begin
						req_q <= 1'b1;
						we_q <= i_cmd_we;
						addr_q <= i_cmd_addr;
						wdata_q <= (i_cmd_addr == ADDR_CHAN) ? (i_cmd_wdata & ~CHAN_RSVD_MASK)
							: i_cmd_wdata;
						state_q <= BUSY;
					end
				end
				BUSY: if (bus.done) begin
					req_q <= 1'b0;
					rsp_q <= 1'b1;
					data_q <= bus.rdata;
					state_q <= IDLE;
				end
				default: state_q <= IDLE;
			endcase
		end
	end
	assign bus.req = req_q && !bus.done;
	assign bus.we = we_q;
	assign bus.addr = addr_q;
	assign bus.wdata = wdata_q;
	assign o_ready = state_q == IDLE;
	assign o_rsp_valid = rsp_q;
	assign o_rsp_data = data_q;
	assign o_refused = ref_q;
endmodule // adc_guard_cpu

//--- adc_guard_dev.sv
// adc_guard_dev: converter mode, channel and result registers with wait
// assumes the master holds a request until done
// assumes a conversion result arrives with a one-cycle valid pulse
// assumes bus signals come from one master on i_core_clk
`timescale 1ns/1ps
module adc_guard_dev (
	input  wire logic                                 i_core_clk,
	input  wire logic                                 i_srst,
	adc_guard_if.device                               bus,
	input  wire logic                                 i_conv_valid,
	input  wire logic [adc_guard_pkg::RESULT_W-1:0]   i_conv_data,
	output logic      [adc_guard_pkg::DATA_W-1:0]     o_mode,
	output logic      [adc_guard_pkg::CHAN_W-1:0]     o_chan,
	output logic                                      o_result_undef
);
	import adc_guard_pkg::*;

	// ------------------------------
	// local sizes
	// ------------------------------
	localparam int                WAIT_W   = $clog2(WAIT_CYCLES + 1);
	localparam logic [WAIT_W-1:0] WAIT_END = WAIT_W'(WAIT_CYCLES);

	// ------------------------------
	// decode helpers
	// ------------------------------
	// write to mode or channel register
	function automatic logic is_cfg_write(
		input logic              we,
		input logic [ADDR_W-1:0] addr
	);
		logic hit;
		hit = 1'b0;
		if (we) begin
			if (addr == ADDR_MODE) begin
				hit = 1'b1;
			end
			if (addr == ADDR_CHAN) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	// access that gets wait cycles
	function automatic logic is_slow(
		input logic              we,
		input logic [ADDR_W-1:0] addr
	);
		logic hit;
		hit = is_cfg_write(we, addr);
		if (!we && addr == ADDR_RESULT) begin
			hit = 1'b1;
		end
		return hit;
	endfunction

	// read word for one address, zero extended
	function automatic logic [15:0] read_word(
		input logic [ADDR_W-1:0]   addr,
		input logic [DATA_W-1:0]   mode,
		input logic [DATA_W-1:0]   chan,
		input logic [RESULT_W-1:0] result
	);
		logic [15:0] word;
		word = 16'h0000;
		case (addr)
			ADDR_MODE: begin
				word = {8'h00, mode};
			end
			ADDR_CHAN: begin
				word = {8'h00, chan};
			end
			ADDR_RESULT: begin
				word = {6'h00, result};
			end
			default: begin
				word = 16'h0000;
			end
		endcase
		return word;
	endfunction

	// ------------------------------
	// state
	// ------------------------------
	logic [WAIT_W-1:0]   wait_cnt_q;
	logic                done_q;
	logic [15:0]         rdata_q;

	logic [DATA_W-1:0]   mode_q;
	logic [DATA_W-1:0]   chan_q;
	logic [RESULT_W-1:0] result_q;
	logic                undef_q;

	// ------------------------------
	// access decode
	// ------------------------------
	logic                hit_mode;
	logic                hit_chan;

	logic                access;
	logic                slow;
	logic                waiting;
	logic                commit;
	logic                mode_write;
	logic                chan_write;
	logic                cfg_commit;
	logic                read_commit;

	// a request counts once; done_q masks the cycle that answers it
	assign hit_mode    = bus.addr == ADDR_MODE;
	assign hit_chan    = bus.addr == ADDR_CHAN;
	assign access      = bus.req && !done_q;
	assign slow        = access && is_slow(bus.we, bus.addr);
	assign waiting     = slow && (wait_cnt_q != WAIT_END);
	assign commit      = access && !waiting;
	assign mode_write  = commit && bus.we && hit_mode;
	assign chan_write  = commit && bus.we && hit_chan;
	assign cfg_commit  = commit && is_cfg_write(bus.we, bus.addr);
	assign read_commit = commit && !bus.we;

	// ------------------------------
	// wait insertion
	// ------------------------------
	// count wait cycles on a slow access, then let it commit
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			wait_cnt_q <= '0;
		end else if (waiting) begin
			wait_cnt_q <= wait_cnt_q + WAIT_W'(1);
		end else begin
			wait_cnt_q <= '0;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			done_q <= 1'b0;
		end else begin
			done_q <= commit;
		end
	end

	assign bus.wait_n = !waiting;
	assign bus.done   = done_q;

	// ------------------------------
	// mode and channel registers
	// ------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			mode_q <= MODE_RESET;
		end else if (mode_write) begin
			mode_q <= bus.wdata;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			chan_q <= CHAN_RESET;
		end else if (chan_write) begin
			chan_q <= bus.wdata & ~CHAN_RSVD_MASK;
		end
	end

	// ------------------------------
	// conversion result
	// ------------------------------
	// a config write in the same cycle as a new result wins
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			result_q <= RESULT_RESET;
		end else if (i_conv_valid && !cfg_commit) begin
			result_q <= i_conv_data;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			undef_q <= 1'b0;
		end else if (cfg_commit) begin
			undef_q <= 1'b1;
		end else if (i_conv_valid) begin
			undef_q <= 1'b0;
		end
	end

	// ------------------------------
	// read data
	// ------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			rdata_q <= 16'h0000;
		end else if (read_commit) begin
			rdata_q <= read_word(bus.addr, mode_q, chan_q, result_q);
		end
	end

	// ------------------------------
	// outputs
	// ------------------------------
	assign bus.rdata      = rdata_q;
	assign o_mode         = mode_q;
	assign o_chan         = chan_q[CHAN_W-1:0];
	assign o_result_undef = undef_q;
endmodule // adc_guard_dev

//--- adc_guard_if.sv
// adc_guard_if: register bus between cpu master and converter guard
// assumes both ends on i_core_clk
`timescale 1ns/1ps
interface adc_guard_if;
	import adc_guard_pkg::*;
	logic                req;
	logic                we;
	logic [ADDR_W-1:0]   addr;
	logic [DATA_W-1:0]   wdata;
	logic [15:0]         rdata;
	logic                wait_n;
	logic                done;
	modport device (input req, we, addr, wdata, output rdata, wait_n, done);
	modport cpu    (output req, we, addr, wdata, input rdata, wait_n, done);
endinterface

//--- adc_guard_pkg.sv
// adc_guard_pkg: shared constants for the converter register access guard
// assumes one core clock, synchronous active-high reset
// How it works
// - software writes zero to channel bits 3..7
// - mode register write gets one wait cycle
// - no mode write on stopped main oscillator
// - channel register write gets one wait cycle
// - no channel write on stopped main oscillator
// - mode or channel write spoils the result
// - read result after conversion, before rewrites
// - result register read gets one wait cycle
// - no result read on stopped main oscillator
package adc_guard_pkg;
	localparam int          ADDR_W           = 2;
	localparam int          DATA_W           = 8;
	localparam int          RESULT_W         = 10;
	localparam int          CHAN_W           = 3;
	localparam logic [1:0]  ADDR_MODE        = 2'h0;
	localparam logic [1:0]  ADDR_CHAN        = 2'h1;
	localparam logic [1:0]  ADDR_RESULT      = 2'h2;
	localparam logic [7:0]  MODE_RESET       = 8'h00;
	localparam logic [7:0]  CHAN_RESET       = 8'h00;
	localparam logic [9:0]  RESULT_RESET     = 10'h000;
	localparam int          WAIT_CYCLES      = 1;
	localparam logic [7:0]  CHAN_RSVD_MASK   = 8'hF8;
endpackage

//--- tb_top.sv
// tb_top: both guard ends joined by the interface
// assumes a 200 MHz core clock
`timescale 1ns/1ps
module tb_top;
	import adc_guard_pkg::*;
	// ----
	// bench
	// ----
	logic        clk = 0, srst = 1, cv = 0, c_vld = 0, c_we = 0, osc_off = 0;
	logic [1:0]  c_addr = 0;
	logic [7:0]  c_wd = 0, mode;
	logic [9:0]  cd = 0;
	logic [2:0]  chan;
	logic [15:0] rsp_data;
	logic        undef, ready, rsp_v, refused;
	int          error_cnt = 0, comparisons = 0, cyc = 0, lat;
	always #2.5 clk = ~clk;
	adc_guard_if bus_if();
	adc_guard_dev adc_guard_dev_i(.i_core_clk(clk), .i_srst(srst), .bus(bus_if),
		.i_conv_valid(cv), .i_conv_data(cd), .o_mode(mode), .o_chan(chan), .o_result_undef(undef));
	adc_guard_cpu adc_guard_cpu_i(.i_core_clk(clk), .i_srst(srst), .bus(bus_if),
		.i_cmd_valid(c_vld), .i_cmd_we(c_we), .i_cmd_addr(c_addr), .i_cmd_wdata(c_wd),
		.i_sub_clk_osc_off(osc_off), .i_conv_done(cv), .o_ready(ready),
		.o_rsp_valid(rsp_v), .o_rsp_data(rsp_data), .o_refused(refused));
	adc_guard_checker adc_guard_checker_i(.i_core_clk(clk), .i_srst(srst), .req(bus_if.req),
		.we(bus_if.we), .addr(bus_if.addr), .wdata(bus_if.wdata), .wait_n(bus_if.wait_n),
		.done(bus_if.done));
	task automatic give_verdict;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic w, input logic [1:0] a, input logic [7:0] d);
		lat = 0;
		@(negedge clk);
		while (!ready) @(negedge clk);
		{c_vld, c_we, c_addr, c_wd} = {1'b1, w, a, d};
		do begin
			@(negedge clk);
			lat++;
			if (lat == 1) c_vld = 0;
		end while (!rsp_v && !refused && lat < 20);
	endtask
	task automatic t_reset;
		chk(mode, MODE_RESET);
		chk(chan, CHAN_RESET[CHAN_W-1:0]);
		chk(undef, 0);
		chk(ready, 1);
	endtask
	task automatic t_readback;
		cmd(0, ADDR_MODE, 0);
		chk(lat, 3);
		chk(rsp_data, 16'h00A5);
		cmd(0, ADDR_CHAN, 0);
		chk(lat, 3);
		chk(rsp_data, 16'h0006);
	endtask
	task automatic t_spoil;
		cmd(1, ADDR_CHAN, 8'h03);
		chk(lat, 4);
		chk(chan, 3'h3);
		chk(undef, 1);
		cmd(0, ADDR_RESULT, 0);
		chk(lat, 1);
	endtask
	task automatic t_mode;
		cmd(1, ADDR_MODE, 8'hA5);
		chk(lat, 4);
		chk(mode, 8'hA5);
		chk(undef, 1);
	endtask
	task automatic t_chan;
		cmd(1, ADDR_CHAN, 8'hFE);
		chk(lat, 4);
		chk(chan, 3'h6);
		cmd(1, 2'h3, 8'h5A);
		chk(lat, 3);
	endtask
	task automatic t_result;
		cmd(0, ADDR_RESULT, 0);
		chk(lat, 1);
		@(negedge clk);
		{cv, cd} = {1'b1, 10'h3C5};
		@(negedge clk);
		cv = 0;
		chk(undef, 0);
		cmd(0, ADDR_RESULT, 0);
		chk(lat, 4);
		chk(rsp_data, 16'h03C5);
	endtask
	task automatic t_osc;
		@(negedge clk);
		osc_off = 1;
		cmd(1, ADDR_MODE, 8'h3C);
		chk(lat, 1);
		chk(mode, 8'hA5);
		cmd(1, ADDR_CHAN, 0);
		chk(lat, 1);
		cmd(0, ADDR_RESULT, 0);
		chk(lat, 1);
		@(negedge clk);
		osc_off = 0;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		@(negedge clk);
		srst = 0;
		t_reset();
		t_mode();
		t_chan();
		t_readback();
		t_result();
		t_osc();
		t_spoil();
		give_verdict();
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			give_verdict();
		end
	end
endmodule // tb_top
